/* File: include/dac_ctrl_pkg.sv */
// shared constants for the audio dac control port
package dac_ctrl_pkg;
    // upper five bits of the slave address (arbitrary value)
    localparam logic [4:0] ADDR_FIXED = 5'h09;
    localparam logic [2:0] REG_LEFT_ATT = 3'h0;
    localparam logic [2:0] REG_RIGHT_ATT = 3'h1;
    localparam logic [2:0] REG_FORMAT = 3'h3;
    localparam logic [2:0] REG_OUT_CTRL = 3'h4;
    localparam int SUB_SEL_LSB = 0;
    localparam int RATE_GROUP_LSB = 6;
    localparam int ATTEN_APPLY_BIT = 0;
    localparam int ZERO_MUTE_EN_BIT = 1;
    localparam int DAC_OUT_OFF_BIT = 2;
    localparam logic [7:0] ATT_RESET = 8'hff;
    localparam logic [7:0] OUT_CTRL_RESET = 8'h00;
    localparam logic [1:0] RATE_RESET = 2'h0;
    localparam logic [1:0] RATE_44K1 = 2'h0;
    localparam logic [1:0] RATE_48K = 2'h1;
    localparam logic [1:0] RATE_32K = 2'h2;
    localparam int ZERO_RUN_CYCLES = 65536;
    localparam logic [16:0] ZERO_RUN_LAST = 17'h0ffff;
endpackage : dac_ctrl_pkg

/* File: rtl/audio_dac_control_port.sv */
// two-wire write-only control port with output control and zero detect
`timescale 1ns/1ps
`default_nettype none
module audio_dac_control_port
#(
    parameter int ZERO_RUN = dac_ctrl_pkg::ZERO_RUN_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // two-wire bus pins
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // address select pins
    input wire logic addr_sel_pin0,
    input wire logic addr_sel_pin1,
    // audio serial input
    input wire logic audio_bit_clock,
    input wire logic audioDataL,
    input wire logic audioDataR,
    // output control
    output logic [7:0] attenLeft,
    output logic [7:0] attenRight,
    output logic [1:0] rateGroup,
    output logic rateReserved,
    output logic zeroFlag_b,
    output logic outputsCommonMode,
    output logic busBusy
);
    import dac_ctrl_pkg::*;

    typedef enum {
        IDLE,
        ADDR,
        SUB,
        DATA,
        ACK,
        IGNORE
    } state_t;

    state_t state;
    state_t afterAck;
    logic sclLevel;
    logic sclRise;
    logic sclFall;
    logic sdaLevel;
    logic sdaRise;
    logic sdaFall;
    logic bckRise;
    logic datL1;
    logic datL2;
    logic datR1;
    logic datR2;
    logic sel0a;
    logic sel0b;
    logic sel1a;
    logic sel1b;
    logic [7:0] shiftReg;
    logic [3:0] bitCount;
    logic [2:0] subSel;
    logic [7:0] stageLeft;
    logic [7:0] stageRight;
    logic [7:0] outCtrl;
    logic [16:0] zeroCount;
    logic zeroDetected;
    logic ackDrive;
    logic [7:0] byteIn;
    logic byteDone;
    logic addrMatch;
    logic startSeen;
    logic stopSeen;
    logic [1:0] rateField;
    logic next_commonMode;

    sync_edge u_scl (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .din(scl),
        .level(sclLevel),
        .rise(sclRise),
        .fall(sclFall)
    );
    sync_edge u_sda (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .din(sdaIn),
        .level(sdaLevel),
        .rise(sdaRise),
        .fall(sdaFall)
    );
    sync_edge u_bck (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .din(audio_bit_clock),
        .level(),
        .rise(bckRise),
        .fall()
    );

    assign startSeen = sdaFall & sclLevel;
    assign stopSeen = sdaRise & sclLevel;
    assign byteIn = {shiftReg[6:0], sdaLevel};
    assign byteDone = sclRise & (bitCount == 4'h7);
    // five fixed bits then pins; write bit must be zero
    assign addrMatch = (byteIn[7:3] == ADDR_FIXED)
        & (byteIn[2] == sel1b) & (byteIn[1] == sel0b) & ~byteIn[0];

    // pins and audio data synchronised before use
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sel0a <= 1'b0;
            sel0b <= 1'b0;
            sel1a <= 1'b0;
            sel1b <= 1'b0;
            datL1 <= 1'b0;
            datL2 <= 1'b0;
            datR1 <= 1'b0;
            datR2 <= 1'b0;
        end else begin
            sel0a <= addr_sel_pin0;
            sel0b <= sel0a;
            sel1a <= addr_sel_pin1;
            sel1b <= sel1a;
            datL1 <= audioDataL;
            datL2 <= datL1;
            datR1 <= audioDataR;
            datR2 <= datR1;
        end
    end

    // the synchroniser delay is the slack the bus gets after a stop
    // busy from start to stop
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            busBusy <= 1'b0;
        end else if (startSeen) begin
            busBusy <= 1'b1;
        end else if (stopSeen) begin
            busBusy <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state <= IDLE;
            afterAck <= IDLE;
            shiftReg <= 8'h00;
            bitCount <= 4'h0;
            subSel <= 3'h0;
            ackDrive <= 1'b0;
        end else if (startSeen) begin
            state <= ADDR;
            bitCount <= 4'h0;
            ackDrive <= 1'b0;
        end else if (stopSeen) begin
            state <= IDLE;
            ackDrive <= 1'b0;
        end else begin
            unique case (state)
                IDLE, IGNORE: begin
                    bitCount <= 4'h0;
                end
                ADDR, SUB, DATA: begin
                    if (sclRise) begin
                        shiftReg <= byteIn;
                        bitCount <= bitCount + 4'h1;
                    end
                    if (byteDone) begin
                        // foreign address ignored until next start
                        if (state == ADDR && !addrMatch) begin
                            state <= IGNORE;
                        end else begin
                            state <= ACK;
                            afterAck <= (state == ADDR) ? SUB : DATA;
                            if (state == SUB) begin
                                // low three sub-address bits pick reg
                                subSel <= byteIn[SUB_SEL_LSB +: 3];
                            end
                        end
                    end
                end
                ACK: begin
                    // drive low from falling edge through ninth pulse
                    if (sclFall && !ackDrive) begin
                        ackDrive <= 1'b1;
                    end else if (sclFall && ackDrive) begin
                        ackDrive <= 1'b0;
                        bitCount <= 4'h0;
                        // data phase repeats with no byte limit
                        state <= afterAck;
                    end
                end
            endcase
        end
    end

    // open drain: the level is always low, only the enable moves
    assign sdaOut = 1'b0;
    assign sdaOe = ackDrive;

    // register writes on each completed data byte
    logic dataWrite;
    assign dataWrite = (state == DATA) & byteDone & ~startSeen & ~stopSeen;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            stageLeft <= ATT_RESET;
            stageRight <= ATT_RESET;
            outCtrl <= OUT_CTRL_RESET;
            rateGroup <= RATE_RESET;
            rateReserved <= 1'b0;
        end else if (dataWrite) begin
            unique case (subSel)
                REG_LEFT_ATT: stageLeft <= byteIn;
                REG_RIGHT_ATT: stageRight <= byteIn;
                REG_FORMAT: begin
                    rateGroup <= rateField;
                    // reserved code held as written, only flagged
                    rateReserved <= (rateField == 2'h3);
                end
                REG_OUT_CTRL: outCtrl <= byteIn;
                default: begin
                end
            endcase
        end
    end

    // rate field taken from the data byte
    assign rateField = byteIn[RATE_GROUP_LSB +: 2];

    // both channels load in the same cycle; hold when clear
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            attenLeft <= ATT_RESET;
            attenRight <= ATT_RESET;
        end else if (outCtrl[ATTEN_APPLY_BIT]) begin
            attenLeft <= stageLeft;
            attenRight <= stageRight;
        end
    end

    // count saturates, so a long silence never wraps back
    // count bit clocks with both channels zero
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            zeroCount <= 17'h00000;
            zeroDetected <= 1'b0;
        end else if (bckRise) begin
            if (datL2 | datR2) begin
                // any one restarts and clears flag
                zeroCount <= 17'h00000;
                zeroDetected <= 1'b0;
            end else if (zeroCount >= 17'(ZERO_RUN - 1)) begin
                zeroDetected <= 1'b1;
            end else begin
                zeroCount <= zeroCount + 17'h00001;
            end
        end
    end

    // output-off and zero mute force common mode
    assign next_commonMode = outCtrl[DAC_OUT_OFF_BIT]
        | (outCtrl[ZERO_MUTE_EN_BIT] & zeroDetected);

    // pin-facing flags leave from flops; one clock of lag is harmless
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            zeroFlag_b <= 1'b1;
            outputsCommonMode <= 1'b0;
        end else begin
            zeroFlag_b <= ~zeroDetected;
            outputsCommonMode <= next_commonMode;
        end
    end
endmodule : audio_dac_control_port
`default_nettype wire

/* File: rtl/sync_edge.sv */
// two-flop synchroniser with rise and fall detection
`timescale 1ns/1ps
`default_nettype none
module sync_edge (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // asynchronous input
    input wire logic din,
    // synchronised level and edges
    output logic level,
    output logic rise,
    output logic fall
);
    logic stage1;
    logic stage2;
    logic stage3;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            stage3 <= 1'b1;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end
    assign level = stage2;
    assign rise = stage2 & ~stage3;
    assign fall = ~stage2 & stage3;
endmodule : sync_edge
`default_nettype wire

/* File: testbench/dac_port_checker.sv */
// pin-level assertions for the dac control port
`timescale 1ns/1ps
`default_nettype none
module dac_port_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // bus and audio pins
    input wire logic scl,
    input wire logic sdaIn,
    input wire logic sdaOe,
    input wire logic audioDataL,
    // outputs
    input wire logic [7:0] attenLeft,
    input wire logic [1:0] rateGroup,
    input wire logic rateReserved,
    input wire logic zeroFlag_b,
    input wire logic outputsCommonMode,
    input wire logic busBusy
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    sequence startSeen;
        scl && $fell(sdaIn);
    endsequence
    sequence stopSeen;
        scl && $rose(sdaIn);
    endsequence
    AST_RSV: assert property (rateReserved == (rateGroup == 2'h3))
        else $error("rate flag");
    AST_START: assert property (startSeen |-> ##[1:8] busBusy)
        else $error("no busy");
    AST_STOP: assert property (stopSeen |-> ##[1:8] !busBusy)
        else $error("busy stuck");
    AST_ACK: assert property ($rose(sdaOe) |-> busBusy && !scl)
        else $error("ack out of slot");
    AST_STEADY: assert property (scl && $past(scl, 5) |-> $stable(sdaOe))
        else $error("data moved");
    AST_NZ: assert property (
        audioDataL [*8] ##1 audioDataL [*8] |-> ##[0:6] zeroFlag_b)
        else $error("zero flag stuck");
    AST_CM: assert property (
        $rose(outputsCommonMode) |-> busBusy || !zeroFlag_b)
        else $error("mid level");
    AST_ATT: assert property ($changed(attenLeft) |-> busBusy)
        else $error("atten moved");
    AST_RATE: assert property ($changed(rateGroup) |-> busBusy)
        else $error("rate moved");
endmodule : dac_port_checker
bind audio_dac_control_port dac_port_checker dac_port_checker_i (.*);
`default_nettype wire

/* File: testbench/host_model.sv */
// behavioural two-wire bus master
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // clock
    input wire logic clk_sys,
    // bus wires
    input wire logic sda,
    output logic scl,
    output logic sdaDrv
);
    // quarter bit in clocks; bench may slow it
    int q = 10;
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    task automatic start();
        sdaDrv <= 1'b1;
        tick(q);
        scl <= 1'b1;
        tick(2 * q);
        sdaDrv <= 1'b0;
        tick(q);
        scl <= 1'b0;
    endtask : start
    task automatic bit_io(input logic b, output logic r);
        tick(q);
        sdaDrv <= b;
        tick(q);
        scl <= 1'b1;
        tick(q);
        r = sda;
        tick(q);
        scl <= 1'b0;
    endtask : bit_io
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : send
    task automatic stop();
        tick(q);
        sdaDrv <= 1'b0;
        tick(q);
        scl <= 1'b1;
        tick(q);
        sdaDrv <= 1'b1;
        tick(2 * q);
    endtask : stop
endmodule : host_model
`default_nettype wire

/* File: testbench/test_audio_dac_control_port.sv */
// self-checking bench for the dac control port
`timescale 1ns/1ps
`default_nettype none
module test_audio_dac_control_port;
    import dac_ctrl_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic audio_bit_clock = 1'b0;
    logic addr_sel_pin0 = 1'b0;
    logic addr_sel_pin1 = 1'b0;
    logic audioDataL = 1'b1;
    logic audioDataR = 1'b1;
    logic scl, sdaDrv, sdaOe, sdaOut, rateReserved, zeroFlag_b, busBusy;
    logic outputsCommonMode;
    logic [7:0] attenLeft, attenRight;
    logic [1:0] rateGroup;
    wire logic sda;
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;
    int stL = 255, stR = 255, actL = 255, actR = 255;
    int ctl = 0, rate = 0, zero = 0;
    logic [31:0] rng = 32'h5e4a;
    // pull-up: low only when someone pulls
    assign sda = sdaDrv & ~(sdaOe & ~sdaOut);
    always #2 clk_sys = ~clk_sys;
    initial #3 forever #16 audio_bit_clock = ~audio_bit_clock;
    audio_dac_control_port #(.ZERO_RUN(16)) audio_dac_control_port_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .scl(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_sel_pin0(addr_sel_pin0),
        .addr_sel_pin1(addr_sel_pin1), .audio_bit_clock(audio_bit_clock),
        .audioDataL(audioDataL), .audioDataR(audioDataR),
        .attenLeft(attenLeft), .attenRight(attenRight),
        .rateGroup(rateGroup), .rateReserved(rateReserved),
        .zeroFlag_b(zeroFlag_b), .outputsCommonMode(outputsCommonMode),
        .busBusy(busBusy));
    host_model host_model_i (.clk_sys(clk_sys), .sda(sda), .scl(scl),
        .sdaDrv(sdaDrv));
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    function automatic void apply(input logic [2:0] r, input logic [7:0] v);
        if (r == REG_LEFT_ATT) stL = v;
        if (r == REG_RIGHT_ATT) stR = v;
        if (r == REG_FORMAT) rate = v[7:6];
        if (r == REG_OUT_CTRL) ctl = v;
        if (ctl[0]) begin
            actL = stL;
            actR = stR;
        end
    endfunction : apply
    task automatic cmp(input logic [7:0] got, input int exp, input string m);
        compares++;
        if (got !== 8'(exp)) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h", $time, m, got);
        end
    endtask : cmp
    task automatic chk_all();
        cmp(attenLeft, actL, "attL");
        cmp(attenRight, actR, "attR");
        cmp({6'h0, rateGroup}, rate, "rate");
        cmp({7'h0, rateReserved}, rate == 3, "rsv");
        cmp({7'h0, zeroFlag_b}, !zero, "zf");
        cmp({7'h0, outputsCommonMode}, ctl[2] | (ctl[1] & zero), "cm");
        cmp({7'h0, busBusy}, 0, "busy");
        cmp({7'h0, sdaOe}, 0, "oe");
    endtask : chk_all
    task automatic wr(input logic [6:0] a, input logic [7:0] s,
        input logic [7:0] d[$], input logic rs);
        logic ack;
        logic hit;
        hit = (a == {ADDR_FIXED, addr_sel_pin1, addr_sel_pin0});
        host_model_i.start();
        host_model_i.send({a, 1'b0}, ack);
        cmp({7'h0, ack}, hit, "ack addr");
        // foreign transfers run in full and must leave no trace
        host_model_i.send(s, ack);
        cmp({7'h0, ack}, hit, "ack sub");
        foreach (d[i]) begin
            host_model_i.send(d[i], ack);
            cmp({7'h0, ack}, hit, "ack data");
            if (hit)
                apply(s[2:0], d[i]);
        end
        if (!rs)
            host_model_i.stop();
    endtask : wr
    task automatic end_sim();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        logic [6:0] own;
        logic ackRd;
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk_all();
        for (int p = 0; p < 4; p++) begin
            {addr_sel_pin1, addr_sel_pin0} <= p[1:0];
            @(posedge clk_sys);
            rng = xorshift(rng);
            own = {ADDR_FIXED, p[1:0]};
            wr(own, 8'h00, '{rng[7:0]}, 1'b0);
            chk_all();
            wr(own ^ 7'h10, 8'h01, '{rng[15:8]}, 1'b0);
            chk_all();
        end
        $display("test address done");
        rng = xorshift(rng);
        wr(own, 8'h01, '{rng[7:0]}, 1'b1);
        wr(own, 8'h04, '{8'h01}, 1'b0);
        chk_all();
        // read bit set: refused even at our own address
        host_model_i.start();
        host_model_i.send({own, 1'b1}, ackRd);
        cmp({7'h0, ackRd}, 0, "ack read");
        host_model_i.send(8'h00, ackRd);
        host_model_i.send(8'h5a, ackRd);
        cmp({7'h0, ackRd}, 0, "ack rd data");
        host_model_i.stop();
        chk_all();
        host_model_i.q = 40;
        wr(own, 8'h00, '{8'h12, rng[15:8], 8'h00}, 1'b0);
        chk_all();
        host_model_i.q = 10;
        $display("test atten done");
        // reserved bits written as zero
        for (int r = 0; r < 4; r++) begin
            wr(own, 8'h03, '{8'(r << 6)}, 1'b0);
            chk_all();
        end
        wr(own, 8'h04, '{8'h04}, 1'b0);
        chk_all();
        wr(own, 8'h04, '{8'h00}, 1'b0);
        $display("test control done");
        audioDataL <= 1'b0;
        repeat (200) @(posedge clk_sys);
        chk_all();
        audioDataR <= 1'b0;
        repeat (200) @(posedge clk_sys);
        zero = 1;
        chk_all();
        wr(own, 8'h04, '{8'h02}, 1'b0);
        chk_all();
        audioDataL <= 1'b1;
        repeat (40) @(posedge clk_sys);
        zero = 0;
        chk_all();
        $display("test zero done");
        end_sim();
    end
endmodule : test_audio_dac_control_port
`default_nettype wire
